/* logic/dwrc_dword_cmp.sv */
// Unsigned compare of two 32-bit values built from 16-bit halves.
// Assumes both halves of each operand are presented together.
`timescale 1ns/1ns
`default_nettype none
module dwrc_dword_cmp (
   // Operand halves
   input wire logic [15:0] first_operand_low_word,
   input wire logic [15:0] first_operand_high_word,
   input wire logic [15:0] second_operand_low_word,
   input wire logic [15:0] second_operand_high_word,
   // Outcome
   output logic greater,
   output logic equal,
   output logic less
);
   logic [31:0] first_value;
   logic [31:0] second_value;
   assign first_value = {first_operand_high_word, first_operand_low_word};
   assign second_value = {second_operand_high_word, second_operand_low_word};
   // Unsigned magnitudes; exactly one outcome is true
   assign greater = first_value > second_value;
   assign equal = first_value == second_value;
   assign less = first_value < second_value;
endmodule
`default_nettype wire

/* logic/dwrc_pkg.sv */
// Constants shared by the double-word and range compare datapath.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package dwrc_pkg;
   // Data widths and data area
   localparam int WORD_W = 16;
   localparam int ADDR_W = 10;
   localparam int AREA_WORDS = 64;
   localparam int AREA_IDX_W = 6;
   localparam int RANGE_COUNT = 16;
   localparam int BLOCK_WORDS = 32;
   // Highest base index that keeps the 32-word block inside the area
   localparam logic [15:0] BLOCK_BASE_MAX = 16'h0020;
   // Register byte offsets
   localparam logic [9:0] CTRL_OFFSET = 10'h000;
   localparam logic [9:0] SCAN_OFFSET = 10'h004;
   localparam logic [9:0] STATUS_OFFSET = 10'h008;
   localparam logic [9:0] OP1_LO_OFFSET = 10'h00C;
   localparam logic [9:0] OP1_HI_OFFSET = 10'h010;
   localparam logic [9:0] OP2_LO_OFFSET = 10'h014;
   localparam logic [9:0] OP2_HI_OFFSET = 10'h018;
   localparam logic [9:0] COMPARE_WORD_OFFSET = 10'h01C;
   localparam logic [9:0] LIMIT_BASE_OFFSET = 10'h020;
   localparam logic [9:0] RESULT_OFFSET = 10'h024;
   localparam logic [9:0] FUNC_CODE_OFFSET = 10'h028;
   localparam logic [9:0] AREA_OFFSET = 10'h100;
   // Control register fields
   localparam int CTRL_DWORD_EXEC_BIT = 0;
   localparam int CTRL_RANGE_EXEC_BIT = 1;
   localparam int CTRL_INDIRECT_BIT = 2;
   // Status register fields
   localparam int STATUS_ERROR_BIT = 3;
   localparam int STATUS_GREATER_BIT = 5;
   localparam int STATUS_EQUAL_BIT = 6;
   localparam int STATUS_LESS_BIT = 7;
   // Reset values and the range compare function code
   localparam logic [15:0] FUNC_CODE_RESET = 16'h0068;
   localparam logic [15:0] RANGE_FUNC_CODE = 16'h0068;
   localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

/* logic/dwrc_range_cell.sv */
// One range of the range block compare: hit test of a word against two limits.
// Assumes unsigned 16-bit operands.
`timescale 1ns/1ns
`default_nettype none
module dwrc_range_cell (
   // Operands
   input wire logic [15:0] compare_word,
   input wire logic [15:0] lower_limit,
   input wire logic [15:0] upper_limit,
   // Result
   output logic hit
);
   logic ordered;
   assign ordered = lower_limit <= upper_limit;
   // Reversed limits: hit only inside the span of the two words
   assign hit = ordered ? (compare_word >= lower_limit && compare_word <= upper_limit)
                        : (compare_word >= upper_limit && compare_word <= lower_limit);
endmodule
`default_nettype wire

/* logic/dwrc_top.sv */
// Double-word compare and range block compare datapath with Avalon-MM registers.
// Assumes one 25 MHz clock; a write to the scan register marks one program scan.
// How it works
// - Double-word compare off: no compare, flags keep their values.
// - Each operand is high word above low word, 32 bits.
// - Double-word operands compare as unsigned magnitudes.
// - Outcome goes to status flags, not to a destination word.
// - Error flag on non-BCD indirect address or address beyond area.
// - Range compare off: skipped, result word unchanged.
// - Block of 32 words forms sixteen lower/upper limit pairs.
// - Hit when lower limit <= compare word <= upper limit.
// - Hit in range n sets result bit n.
// - Bits without a hit are cleared; whole word rewritten.
// - Reversed limits: bit cleared when word lies outside their span.
// - Error flag when the 32-word block passes the area end.
// - Range compare runs only while its function code is assigned.
// - Enabled compares execute again on every scan.
// - Compare word immediate or from memory; block in memory, result in a register.
// - Less flag readable as status bit 7 beside greater and equal.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dwrc_top (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Comparison flags
   output logic greater_flag,
   output logic equal_flag,
   output logic less_flag,
   output logic error_flag
);
   ////////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [15:0] data_area [0:63];
   logic [15:0] ctrl_reg;
   logic [15:0] op1_lo_reg;
   logic [15:0] op1_hi_reg;
   logic [15:0] op2_lo_reg;
   logic [15:0] op2_hi_reg;
   logic [15:0] compare_word_reg;
   logic [15:0] limit_block_base_reg;
   logic [15:0] result_reg;
   logic [15:0] func_code_reg;
   logic scan_pending_reg;
   logic wait_reg;
   logic [31:0] readdata_reg;
   logic greater_reg;
   logic equal_reg;
   logic less_reg;
   logic error_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode: one wait state, access completes on the second cycle
   logic request;
   logic commit_write;
   logic in_area;
   logic [5:0] area_index;
   logic [15:0] lane_mask;
   logic [15:0] wdata16;
   logic reg_write;
   logic area_write;
   assign request = read | write;
   assign commit_write = write && !wait_reg;
   // Everything from the area offset up aliases onto the 64 area words
   assign in_area = address >= dwrc_pkg::AREA_OFFSET;
   assign reg_write = commit_write && !in_area;
   assign area_write = commit_write && in_area;
   assign area_index = address[7:2];
   assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wdata16 = writedata[15:0];

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [15:0] mask);
      merge = (old & ~mask) | (wd & mask);
   endfunction

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg <= 1'b1;
      end else if (request && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status word: error bit 3, greater 5, equal 6, less 7
   logic [15:0] status_word;
   always_comb begin
      status_word = dwrc_pkg::WORD_RESET;
      status_word[dwrc_pkg::STATUS_ERROR_BIT] = error_reg;
      status_word[dwrc_pkg::STATUS_GREATER_BIT] = greater_reg;
      status_word[dwrc_pkg::STATUS_EQUAL_BIT] = equal_reg;
      status_word[dwrc_pkg::STATUS_LESS_BIT] = less_reg;
   end

   logic [15:0] read_word;
   always_comb begin
      read_word = dwrc_pkg::WORD_RESET;
      if (in_area) begin
         read_word = data_area[area_index];
      end else begin
         unique case (address)
            dwrc_pkg::CTRL_OFFSET: read_word = ctrl_reg;
            dwrc_pkg::STATUS_OFFSET: read_word = status_word;
            dwrc_pkg::OP1_LO_OFFSET: read_word = op1_lo_reg;
            dwrc_pkg::OP1_HI_OFFSET: read_word = op1_hi_reg;
            dwrc_pkg::OP2_LO_OFFSET: read_word = op2_lo_reg;
            dwrc_pkg::OP2_HI_OFFSET: read_word = op2_hi_reg;
            dwrc_pkg::COMPARE_WORD_OFFSET: read_word = compare_word_reg;
            dwrc_pkg::LIMIT_BASE_OFFSET: read_word = limit_block_base_reg;
            dwrc_pkg::RESULT_OFFSET: read_word = result_reg;
            dwrc_pkg::FUNC_CODE_OFFSET: read_word = func_code_reg;
            default: read_word = dwrc_pkg::WORD_RESET;
         endcase
      end
   end

   // Read data captured in the first cycle, stands while waitrequest drops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         readdata_reg <= 32'h0000_0000;
      end else if (read && wait_reg) begin
         readdata_reg <= {16'h0000, read_word};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= dwrc_pkg::WORD_RESET;
         op1_lo_reg <= dwrc_pkg::WORD_RESET;
         op1_hi_reg <= dwrc_pkg::WORD_RESET;
         op2_lo_reg <= dwrc_pkg::WORD_RESET;
         op2_hi_reg <= dwrc_pkg::WORD_RESET;
         compare_word_reg <= dwrc_pkg::WORD_RESET;
         limit_block_base_reg <= dwrc_pkg::WORD_RESET;
         func_code_reg <= dwrc_pkg::FUNC_CODE_RESET;
      end else if (reg_write) begin
         unique case (address)
            dwrc_pkg::CTRL_OFFSET: ctrl_reg <= merge(ctrl_reg, wdata16, lane_mask);
            dwrc_pkg::OP1_LO_OFFSET: op1_lo_reg <= merge(op1_lo_reg, wdata16, lane_mask);
            dwrc_pkg::OP1_HI_OFFSET: op1_hi_reg <= merge(op1_hi_reg, wdata16, lane_mask);
            dwrc_pkg::OP2_LO_OFFSET: op2_lo_reg <= merge(op2_lo_reg, wdata16, lane_mask);
            dwrc_pkg::OP2_HI_OFFSET: op2_hi_reg <= merge(op2_hi_reg, wdata16, lane_mask);
            dwrc_pkg::COMPARE_WORD_OFFSET:
               compare_word_reg <= merge(compare_word_reg, wdata16, lane_mask);
            dwrc_pkg::LIMIT_BASE_OFFSET:
               limit_block_base_reg <= merge(limit_block_base_reg, wdata16, lane_mask);
            dwrc_pkg::FUNC_CODE_OFFSET:
               func_code_reg <= merge(func_code_reg, wdata16, lane_mask);
            default: ;
         endcase
      end
   end

   // Limit block and memory-held compare words live in the data area
   // No reset: software loads the area before enabling a compare
   always_ff @(posedge clock) begin
      if (area_write) begin
         data_area[area_index] <= merge(data_area[area_index], wdata16, lane_mask);
      end
   end

   // A scan write starts one execution at the next edge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         scan_pending_reg <= 1'b0;
      end else begin
         scan_pending_reg <= reg_write && address == dwrc_pkg::SCAN_OFFSET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Double-word compare
   logic dword_greater;
   logic dword_equal;
   logic dword_less;
   logic dword_run;
   dwrc_dword_cmp u_dword (
      .first_operand_low_word(op1_lo_reg),
      .first_operand_high_word(op1_hi_reg),
      .second_operand_low_word(op2_lo_reg),
      .second_operand_high_word(op2_hi_reg),
      .greater(dword_greater),
      .equal(dword_equal),
      .less(dword_less)
   );
   assign dword_run = scan_pending_reg && ctrl_reg[dwrc_pkg::CTRL_DWORD_EXEC_BIT];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         greater_reg <= 1'b0;
         equal_reg <= 1'b0;
         less_reg <= 1'b0;
      end else if (dword_run) begin
         greater_reg <= dword_greater;
         equal_reg <= dword_equal;
         less_reg <= dword_less;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare word source: immediate or BCD indirect address into the area
   logic bcd_ok;
   logic [15:0] indirect_index;
   logic indirect_bad;
   logic indirect;
   logic [15:0] compare_word;
   logic [3:0] digit_ok;
   logic [15:0] digit_thousands;
   logic [15:0] digit_hundreds;
   logic [15:0] digit_tens;
   logic [15:0] digit_units;
   // Each nibble must be a decimal digit for the address to be usable
   assign digit_ok[0] = compare_word_reg[3:0] <= 4'h9;
   assign digit_ok[1] = compare_word_reg[7:4] <= 4'h9;
   assign digit_ok[2] = compare_word_reg[11:8] <= 4'h9;
   assign digit_ok[3] = compare_word_reg[15:12] <= 4'h9;
   assign bcd_ok = &digit_ok;
   // Digits weighted in 16 bits; the largest sum is 16665, so nothing overflows
   assign digit_thousands = 16'(compare_word_reg[15:12]) * 16'h03e8;
   assign digit_hundreds = 16'(compare_word_reg[11:8]) * 16'h0064;
   assign digit_tens = 16'(compare_word_reg[7:4]) * 16'h000a;
   assign digit_units = 16'(compare_word_reg[3:0]);
   assign indirect_index = digit_thousands + digit_hundreds + digit_tens + digit_units;
   assign indirect = ctrl_reg[dwrc_pkg::CTRL_INDIRECT_BIT];
   assign indirect_bad = indirect && (!bcd_ok
                         || indirect_index >= 16'(dwrc_pkg::AREA_WORDS));
   assign compare_word = indirect ? data_area[indirect_index[5:0]] : compare_word_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Range block compare
   logic block_bad;
   logic range_run;
   logic range_error;
   logic [15:0] hit_mask;
   assign block_bad = limit_block_base_reg > dwrc_pkg::BLOCK_BASE_MAX;
   assign range_run = scan_pending_reg && ctrl_reg[dwrc_pkg::CTRL_RANGE_EXEC_BIT]
                      && func_code_reg == dwrc_pkg::RANGE_FUNC_CODE;
   assign range_error = block_bad || indirect_bad;

   // Block indexes wrap within the area; a base past the limit is flagged instead
   for (genvar n = 0; n < dwrc_pkg::RANGE_COUNT; n++) begin : g_range
      logic [5:0] lower_index;
      logic [5:0] upper_index;
      assign lower_index = limit_block_base_reg[5:0] + 6'(2 * n);
      assign upper_index = lower_index + 6'd1;
      dwrc_range_cell u_cell (
         .compare_word(compare_word),
         .lower_limit(data_area[lower_index]),
         .upper_limit(data_area[upper_index]),
         .hit(hit_mask[n])
      );
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         result_reg <= dwrc_pkg::WORD_RESET;
      end else if (range_run && !range_error) begin
         result_reg <= hit_mask;
      end
   end

   // Error flag follows each execution that ran
   // If both compares run in one scan, the range compare sets the flag
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         error_reg <= 1'b0;
      end else if (range_run) begin
         error_reg <= range_error;
      end else if (dword_run) begin
         error_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign readdata = readdata_reg;
   assign waitrequest = wait_reg;
   assign greater_flag = greater_reg;
   assign equal_flag = equal_reg;
   assign less_flag = less_reg;
   assign error_flag = error_reg;
endmodule
`default_nettype wire

/* verif/double_and_range_compare_bench.sv */
// Self-checking bench for the compare datapath, driven over Avalon-MM.
// Assumes the checker is bound separately and the data area is written first.
`timescale 1ns/1ns
`default_nettype none
module double_and_range_compare_bench;
   logic clock, arst_n, read, write, waitrequest;
   logic [9:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, q;
   logic greater_flag, equal_flag, less_flag, error_flag;
   int fail_count = 0;
   int tests_run = 0;
   dwrc_top DUT (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .greater_flag(greater_flag), .equal_flag(equal_flag),
      .less_flag(less_flag), .error_flag(error_flag));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask
   task automatic end_sim();
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One transfer; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {16'h0000, d};
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] want);
      bus(1'b0, a, 16'h0000);
      check(q, {16'h0000, want});
   endtask
   task automatic scan();
      wr(dwrc_pkg::SCAN_OFFSET, 16'h0000);
      // Pending bit at the commit edge, execution one edge later
      repeat (2) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check({error_flag, greater_flag, equal_flag, less_flag, waitrequest, readdata[0]}, 6'h02);
      rd(dwrc_pkg::FUNC_CODE_OFFSET, 16'h0068);
      rd(10'h0fc, 16'h0000);
   endtask
   task automatic t_dword();
      logic [31:0] o1 [4] = '{32'h0001_0000, 32'h8000_0000, 32'h1234_5678, 32'h1234_5677};
      logic [31:0] o2 [4] = '{32'h0000_ffff, 32'h0000_0001, 32'h1234_5678, 32'h1234_5678};
      logic [3:0] ex [4] = '{4'h4, 4'h4, 4'h2, 4'h1};
      wr(dwrc_pkg::CTRL_OFFSET, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         wr(dwrc_pkg::OP1_LO_OFFSET, o1[i][15:0]);
         wr(dwrc_pkg::OP1_HI_OFFSET, o1[i][31:16]);
         wr(dwrc_pkg::OP2_LO_OFFSET, o2[i][15:0]);
         wr(dwrc_pkg::OP2_HI_OFFSET, o2[i][31:16]);
         scan();
         check({error_flag, greater_flag, equal_flag, less_flag}, ex[i]);
         bus(1'b0, dwrc_pkg::STATUS_OFFSET, 16'h0000);
         check(q & 32'h0000_00e8, {ex[i][0], ex[i][1], ex[i][2], 1'b0, ex[i][3], 3'h0});
      end
      wr(dwrc_pkg::CTRL_OFFSET, 16'h0000);
      wr(dwrc_pkg::OP1_HI_OFFSET, 16'hffff);
      scan();
      check({greater_flag, equal_flag, less_flag}, 1);
   endtask
   task automatic t_range();
      logic [15:0] cw [5] = '{16'hffff, 16'h3000, 16'h5800, 16'h0000, 16'h4fff};
      logic [15:0] ex [5] = '{16'h8000, 16'h0008, 16'h0020, 16'h0001, 16'h0010};
      logic [15:0] lo;
      for (int n = 0; n < 16; n++) begin
         lo = (n == 5) ? 16'h5fff : 16'(n << 12);
         wr(dwrc_pkg::AREA_OFFSET + 10'(8 * n + 128), lo);
         wr(dwrc_pkg::AREA_OFFSET + 10'(8 * n + 132), (n == 5) ? 16'h5000 : lo | 16'h0fff);
      end
      wr(dwrc_pkg::LIMIT_BASE_OFFSET, 16'h0020);
      wr(dwrc_pkg::CTRL_OFFSET, 16'h0002);
      for (int i = 0; i < 5; i++) begin
         wr(dwrc_pkg::COMPARE_WORD_OFFSET, cw[i]);
         scan();
         rd(dwrc_pkg::RESULT_OFFSET, ex[i]);
         check(error_flag, 0);
      end
      wr(dwrc_pkg::CTRL_OFFSET, 16'h0000);
      wr(dwrc_pkg::COMPARE_WORD_OFFSET, 16'h0000);
      scan();
      rd(dwrc_pkg::RESULT_OFFSET, 16'h0010);
      wr(dwrc_pkg::CTRL_OFFSET, 16'h0002);
      wr(dwrc_pkg::FUNC_CODE_OFFSET, 16'h0069);
      scan();
      rd(dwrc_pkg::RESULT_OFFSET, 16'h0010);
      wr(dwrc_pkg::FUNC_CODE_OFFSET, 16'h0068);
      wr(dwrc_pkg::LIMIT_BASE_OFFSET, 16'h0021);
      scan();
      check(error_flag, 1);
      rd(dwrc_pkg::RESULT_OFFSET, 16'h0010);
      wr(dwrc_pkg::LIMIT_BASE_OFFSET, 16'h0020);
      wr(dwrc_pkg::CTRL_OFFSET, 16'h0006);
      cw = '{16'h001a, 16'h0064, 16'h0034, 16'h0000, 16'h0000};
      for (int i = 0; i < 3; i++) begin
         wr(dwrc_pkg::COMPARE_WORD_OFFSET, cw[i]);
         scan();
         check(error_flag, i < 2);
      end
      rd(dwrc_pkg::RESULT_OFFSET, 16'h0002);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 3000);
      fail_count++;
      end_sim();
   end
   initial begin
      arst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 10'h000;
      byteenable = 4'hf;
      writedata = 32'h0000_0000;
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      t_reset();
      t_dword();
      t_range();
      end_sim();
   end
endmodule
`default_nettype wire

/* verif/dwrc_asserts.sv */
// Checker for the compare datapath; sees only the top module ports.
// Assumes one clock domain and the one-wait-state slave timing.
`timescale 1ns/1ns
`default_nettype none
module dwrc_asserts (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Comparison flags
   input wire logic greater_flag,
   input wire logic equal_flag,
   input wire logic less_flag,
   input wire logic error_flag
);
   logic dword_on_reg;
   wire [2:0] flags = {greater_flag, equal_flag, less_flag};
   wire scan_hit = write && !waitrequest && address == dwrc_pkg::SCAN_OFFSET;
   wire ctrl_hit = write && !waitrequest && address == dwrc_pkg::CTRL_OFFSET;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   // Shadow of the double-word enable
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dword_on_reg <= 1'b0;
      end else if (ctrl_hit && byteenable[0]) begin
         dword_on_reg <= writedata[dwrc_pkg::CTRL_DWORD_EXEC_BIT];
      end
   end
   sequence scan_dword;
      scan_hit && dword_on_reg;
   endsequence
   sequence status_read;
      read && !waitrequest && address == dwrc_pkg::STATUS_OFFSET
         && $stable({flags, error_flag});
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_flags_exclusive: assert property ($onehot0(flags))
      else $error("more than one compare flag set");
   a_dword_outcome: assert property (scan_dword |=> ##1 $onehot(flags))
      else $error("double-word compare left no single flag");
   a_dword_off_keep: assert property (scan_hit && !dword_on_reg |=> ##1 $stable(flags))
      else $error("flags changed with double-word compare off");
   a_flags_only_scan: assert property (!scan_hit |=> ##1 $stable({flags, error_flag}))
      else $error("flags changed without a scan");
   a_status_mirror: assert property (status_read |-> readdata[7:5] == {less_flag,
      equal_flag, greater_flag} && readdata[3] == error_flag)
      else $error("status read differs from flag ports");
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_idle: assert property (!read && !write |=> waitrequest)
      else $error("waitrequest low without a request");
   a_upper_zero: assert property (readdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
endmodule
bind dwrc_top dwrc_asserts u_asserts (.clock(clock), .arst_n(arst_n), .address(address),
   .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .greater_flag(greater_flag),
   .equal_flag(equal_flag), .less_flag(less_flag), .error_flag(error_flag));
`default_nettype wire
